// [rtl/plc_ctrl.sv]
// Pulse count level control: edge counter, timeouts, level register, sinks, pump clock
module plc_ctrl #(
	parameter int LATCH_HOLD_CYCLES = plc_pkg::LATCH_HOLD_CYCLES,
	parameter int OFF_TIMEOUT_CYCLES = plc_pkg::OFF_TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pulse_count_protocol,
	output plc_pkg::plc_sink_t [plc_pkg::CHANNELS-1:0] led_current_sinks,
	output logic [plc_pkg::LEVEL_W-1:0] level,
	output logic shutdown,
	output logic pump_clk
);
	localparam logic [plc_pkg::TIMER_W-1:0] LATCH_LAST = plc_pkg::TIMER_W'(LATCH_HOLD_CYCLES - 1);
	localparam logic [plc_pkg::TIMER_W-1:0] LATCH_SAT = plc_pkg::TIMER_W'(LATCH_HOLD_CYCLES);
	localparam logic [plc_pkg::TIMER_W-1:0] OFF_LAST = plc_pkg::TIMER_W'(OFF_TIMEOUT_CYCLES - 1);
	localparam logic [plc_pkg::TIMER_W-1:0] OFF_SAT = plc_pkg::TIMER_W'(OFF_TIMEOUT_CYCLES);
	localparam logic [plc_pkg::PUMP_W-1:0] PUMP_LAST = plc_pkg::PUMP_W'(plc_pkg::PUMP_HALF_CYCLES - 1);

	logic pin_meta_reg;
	logic pin_sync_reg;
	logic pin_prev_reg;
	logic [plc_pkg::TIMER_W-1:0] high_cnt_reg;
	logic [plc_pkg::TIMER_W-1:0] high_cnt_next;
	logic [plc_pkg::TIMER_W-1:0] low_cnt_reg;
	logic [plc_pkg::TIMER_W-1:0] low_cnt_next;
	logic [plc_pkg::LEVEL_W-1:0] cnt_reg;
	logic [plc_pkg::LEVEL_W-1:0] cnt_next;
	logic [plc_pkg::LEVEL_W-1:0] level_reg;
	logic [plc_pkg::LEVEL_W-1:0] level_next;
	logic shutdown_reg;
	logic shutdown_next;
	logic [plc_pkg::PUMP_W-1:0] pump_cnt_reg;
	logic [plc_pkg::PUMP_W-1:0] pump_cnt_next;
	logic pump_reg;
	logic pump_next;
	logic [plc_pkg::CURRENT_W-1:0] rom_current;
	plc_pkg::plc_sink_t sink_reg [plc_pkg::CHANNELS];
	plc_pkg::plc_sink_t sink_next;
	wire rise;
	wire latch_fire;
	wire latch_take;
	wire off_fire;
	wire cnt_full;
	wire pump_wrap;

	// Pin synchroniser
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= pulse_count_protocol;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	// Edge detect and timeouts, each measured by its own saturating timer
	assign rise = pin_sync_reg & ~pin_prev_reg;
	assign high_cnt_next = !pin_sync_reg ? '0 : (high_cnt_reg == LATCH_SAT ? high_cnt_reg : high_cnt_reg + 1'b1);
	assign low_cnt_next = pin_sync_reg ? '0 : (low_cnt_reg == OFF_SAT ? low_cnt_reg : low_cnt_reg + 1'b1);
	assign latch_fire = pin_sync_reg && (high_cnt_reg == LATCH_LAST);
	assign off_fire = !pin_sync_reg && (low_cnt_reg == OFF_LAST);
	assign latch_take = latch_fire && (cnt_reg != plc_pkg::LEVEL_RESET);
	assign cnt_full = (cnt_reg == plc_pkg::LEVEL_MAX);

	// Edge counter saturates at the top level; cleared by latch or shutdown
	assign cnt_next = (latch_fire || off_fire) ? plc_pkg::LEVEL_RESET :
		((rise && !cnt_full) ? cnt_reg + 1'b1 : cnt_reg);

	// Level register and shutdown state
	assign level_next = off_fire ? plc_pkg::LEVEL_RESET : (latch_take ? cnt_reg : level_reg);
	assign shutdown_next = off_fire ? 1'b1 : (latch_take ? 1'b0 : shutdown_reg);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			high_cnt_reg <= '0;
			low_cnt_reg <= '0;
			cnt_reg <= plc_pkg::LEVEL_RESET;
			level_reg <= plc_pkg::LEVEL_RESET;
			shutdown_reg <= 1'b1;
		end else begin
			high_cnt_reg <= high_cnt_next;
			low_cnt_reg <= low_cnt_next;
			cnt_reg <= cnt_next;
			level_reg <= level_next;
			shutdown_reg <= shutdown_next;
		end
	end

	// Current lookup
	plc_level_rom plc_level_rom_i (
		.clk(clk),
		.reset(reset),
		.level(level_reg),
		.current(rom_current)
	);

	// All sinks follow the one level register
	assign sink_next.enable = (level_reg != plc_pkg::LEVEL_RESET) && (rom_current != plc_pkg::CURRENT_RESET);
	assign sink_next.current = rom_current;

	genvar ch;
	generate
		for (ch = 0; ch < plc_pkg::CHANNELS; ch++) begin : g_sink
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					sink_reg[ch] <= '0;
				end else begin
					sink_reg[ch] <= sink_next;
				end
			end
			assign led_current_sinks[ch] = sink_reg[ch];
		end
	endgenerate

	// Charge pump clock: fixed divider, runs whenever not in shutdown
	assign pump_wrap = (pump_cnt_reg == PUMP_LAST);
	assign pump_cnt_next = (shutdown_reg || pump_wrap) ? '0 : pump_cnt_reg + 1'b1;
	assign pump_next = shutdown_reg ? 1'b0 : (pump_wrap ? ~pump_reg : pump_reg);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pump_cnt_reg <= '0;
			pump_reg <= 1'b0;
		end else begin
			pump_cnt_reg <= pump_cnt_next;
			pump_reg <= pump_next;
		end
	end

	assign level = level_reg;
	assign shutdown = shutdown_reg;
	assign pump_clk = pump_reg;

	// Checks
	AST_EDGE_COUNT: assert property (@(posedge clk) disable iff (reset)
		rise && !cnt_full |=> cnt_reg == $past(cnt_reg) + 4'h1)
		else $error("Rising edge not counted");

	AST_LEVEL_MAP: assert property (@(posedge clk) disable iff (reset)
		level_reg == 4'h1 ##1 level_reg == 4'h1 |=> sink_reg[0].current == 8'hC8 && sink_reg[0].enable)
		else $error("Level 1 does not select top current");

	AST_LEVEL_LOW: assert property (@(posedge clk) disable iff (reset)
		level_reg == 4'hE ##1 level_reg == 4'hE |=> sink_reg[3].current == 8'h12)
		else $error("Level 14 does not select lowest current");

	AST_LATCH: assert property (@(posedge clk) disable iff (reset)
		latch_fire && cnt_reg != 4'h0 |=> level_reg == $past(cnt_reg) && !shutdown_reg)
		else $error("Count not latched after high hold");

	AST_CNT_CLEAR: assert property (@(posedge clk) disable iff (reset)
		latch_fire |=> cnt_reg == 4'h0 ##1 level_reg == $past(level_reg))
		else $error("Counter not cleared after latch");

	AST_OFF: assert property (@(posedge clk) disable iff (reset)
		off_fire |=> level_reg == 4'h0 && shutdown_reg ##2 !sink_reg[0].enable && !sink_reg[2].enable)
		else $error("Low timeout did not shut down");

	AST_NO_EARLY_OFF: assert property (@(posedge clk) disable iff (reset)
		$rose(shutdown_reg) |-> $past(low_cnt_reg) == OFF_LAST && !$past(pin_sync_reg))
		else $error("Shutdown before low timeout");

	AST_SINKS_SAME: assert property (@(posedge clk) disable iff (reset)
		sink_reg[0] == sink_reg[1] && sink_reg[1] == sink_reg[2] && sink_reg[2] == sink_reg[3])
		else $error("Channels differ");

	AST_PUMP: assert property (@(posedge clk) disable iff (reset)
		$rose(pump_reg) && !shutdown_reg |-> (pump_reg || shutdown_reg)[*5] ##1 (!pump_reg || shutdown_reg))
		else $error("Pump half period wrong");

	AST_HOLD_ZERO: assert property (@(posedge clk) disable iff (reset)
		level_reg == 4'h0 && !latch_take |=> level_reg == 4'h0)
		else $error("Level left zero without latch");

	AST_LEVEL_RANGE: assert property (@(posedge clk) disable iff (reset)
		level_reg <= 4'hE)
		else $error("Level above top setting");

	AST_CNT_SAT: assert property (@(posedge clk) disable iff (reset)
		rise && cnt_full |=> cnt_reg == 4'hE)
		else $error("Edge counter left its top value");

	AST_CNT_QUIET: assert property (@(posedge clk) disable iff (reset)
		!rise && !latch_fire && !off_fire |=> cnt_reg == $past(cnt_reg))
		else $error("Edge counter moved without an edge");

	AST_LEVEL_CAUSE: assert property (@(posedge clk) disable iff (reset)
		level_reg != $past(level_reg) |-> $past(latch_fire) || $past(off_fire))
		else $error("Level changed without a timeout");

	AST_SHUT_LEVEL: assert property (@(posedge clk) disable iff (reset)
		shutdown_reg |-> level_reg == 4'h0)
		else $error("Level nonzero in shutdown");

	AST_SHUT_SINKS: assert property (@(posedge clk) disable iff (reset)
		level_reg == 4'h0 |=> !sink_reg[1].enable)
		else $error("Sink enabled at level zero");

	AST_OFF_CNT: assert property (@(posedge clk) disable iff (reset)
		off_fire |=> cnt_reg == 4'h0)
		else $error("Edge counter kept through shutdown");

	AST_SINKS_ON: assert property (@(posedge clk) disable iff (reset)
		level_reg != 4'h0 ##1 level_reg != 4'h0 |=> sink_reg[2].enable)
		else $error("Sink off at a nonzero level");

	AST_PUMP_STOP: assert property (@(posedge clk) disable iff (reset)
		shutdown_reg |=> !pump_reg)
		else $error("Pump running in shutdown");

	AST_PUMP_LOW: assert property (@(posedge clk) disable iff (reset)
		$fell(pump_reg) && !shutdown_reg |-> (!pump_reg || shutdown_reg)[*5] ##1 (pump_reg || shutdown_reg))
		else $error("Pump low half period wrong");

	COV_LATCH: cover property (@(posedge clk) disable iff (reset) latch_take);
	COV_OFF: cover property (@(posedge clk) disable iff (reset) off_fire && level_reg != 4'h0);
	COV_FULL: cover property (@(posedge clk) disable iff (reset) rise && cnt_full);
	COV_PUMP: cover property (@(posedge clk) disable iff (reset) $fell(pump_reg));
	COV_RELATCH: cover property (@(posedge clk) disable iff (reset) latch_take && level_reg != 4'h0);
endmodule // plc_ctrl

// [rtl/plc_level_rom.sv]
// Level to sink current lookup with registered output
module plc_level_rom (
	input wire logic clk,
	input wire logic reset,
	input wire logic [plc_pkg::LEVEL_W-1:0] level,
	output logic [plc_pkg::CURRENT_W-1:0] current
);
	logic [plc_pkg::CURRENT_W-1:0] current_next;

	// Current in 0.1 mA steps, about 1.5 dB apart
	always_comb begin
		case (level)
			4'h1: current_next = 8'hC8;
			4'h2: current_next = 8'hAA;
			4'h3: current_next = 8'h8C;
			4'h4: current_next = 8'h78;
			4'h5: current_next = 8'h64;
			4'h6: current_next = 8'h56;
			4'h7: current_next = 8'h46;
			4'h8: current_next = 8'h3C;
			4'h9: current_next = 8'h32;
			4'hA: current_next = 8'h2A;
			4'hB: current_next = 8'h24;
			4'hC: current_next = 8'h1E;
			4'hD: current_next = 8'h18;
			4'hE: current_next = 8'h12;
			default: current_next = plc_pkg::CURRENT_RESET;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			current <= plc_pkg::CURRENT_RESET;
		end else begin
			current <= current_next;
		end
	end
endmodule // plc_level_rom

// [rtl/plc_pkg.sv]
// Constants and types of the pulse count LED level control
// Contract
// - Count each rising edge on the control pin; decode the count as one of 14 levels.
// - Levels 1 to 14 select falling sink currents, 20.0 mA down to 1.8 mA.
// - Pin held high at least 500 us copies the count into the level register.
// - After a latch the edge counter is cleared for the next burst.
// - Pin low at least 500 us enters shutdown, clears the level, disables outputs.
// - Counting works for any pulse timing, from about 15 kHz up to 1 MHz.
// - All four sinks are driven from the one latched level register.
// - Charge pump switches at a fixed 1 MHz at every level 1 to 14, and stops in shutdown.
package plc_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CLK_FREQ_KHZ = 10000;
	localparam int LATCH_HOLD_NS = 500000;
	localparam int OFF_TIMEOUT_NS = 500000;
	localparam int LATCH_HOLD_CYCLES = (LATCH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_TIMEOUT_CYCLES = (OFF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PUMP_FREQ_KHZ = 1000;
	localparam int PUMP_HALF_CYCLES = CLK_FREQ_KHZ / (2 * PUMP_FREQ_KHZ);
	localparam int CHANNELS = 4;
	localparam int LEVEL_W = 4;
	localparam int CURRENT_W = 8;
	localparam int TIMER_W = 16;
	localparam int PUMP_W = 3;
	localparam logic [LEVEL_W-1:0] LEVEL_MAX = 4'hE;
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
	localparam logic [CURRENT_W-1:0] CURRENT_RESET = 8'h00;

	// One current sink: enable and current in steps of 0.1 mA
	typedef struct packed {
		logic enable;
		logic [CURRENT_W-1:0] current;
	} plc_sink_t;
endpackage

// [testbench/plc_host_model.sv]
// Host that drives the control pin with pulse bursts
module plc_host_model (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'b0;
	// Burst of n pulses, final high kept for the latch hold
	task automatic send(input int n, input int hc, input int lc, input int hold);
		@(negedge clk);
		repeat (n) begin
			pin = 1'b0;
			repeat (lc) @(negedge clk);
			pin = 1'b1;
			repeat (hc) @(negedge clk);
		end
		repeat (hold) @(negedge clk);
	endtask
	// Pin released: the pull-down takes it low
	task automatic idle(input int cyc);
		@(negedge clk);
		pin = 1'b0;
		repeat (cyc) @(negedge clk);
	endtask
endmodule // plc_host_model

// [testbench/pulse_count_led_level_ctrl_bench.sv]
// Testbench of the pulse count LED level control
module pulse_count_led_level_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int L = 800;
	localparam logic [7:0] CUR [1:14] = '{8'hC8, 8'hAA, 8'h8C, 8'h78, 8'h64, 8'h56, 8'h46,
		8'h3C, 8'h32, 8'h2A, 8'h24, 8'h1E, 8'h18, 8'h12};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic pin;
	plc_pkg::plc_sink_t [plc_pkg::CHANNELS-1:0] sinks;
	logic [plc_pkg::LEVEL_W-1:0] level;
	logic shutdown;
	logic pump_clk;
	int errors = 0;
	int checks_done = 0;
	always #50 clk = ~clk;
	plc_host_model plc_host_model_i (.clk(clk), .pin(pin));
	plc_ctrl #(.LATCH_HOLD_CYCLES(L), .OFF_TIMEOUT_CYCLES(L)) plc_ctrl_i (
		.clk(clk),
		.reset(reset),
		.pulse_count_protocol(pin),
		.led_current_sinks(sinks),
		.level(level),
		.shutdown(shutdown),
		.pump_clk(pump_clk)
	);
	task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_sinks(input logic en, input logic [7:0] cur);
		for (int c = 0; c < plc_pkg::CHANNELS; c++) begin
			chk_val("sink enable", {7'h00, en}, {7'h00, sinks[c].enable});
			chk_val("sink current", cur, sinks[c].current);
		end
	endtask
	task automatic chk_state(input logic [3:0] lv, input logic sd);
		chk_val("level", {4'h0, lv}, {4'h0, level});
		chk_val("shutdown", {7'h00, sd}, {7'h00, shutdown});
		chk_sinks(lv != 4'h0, (lv == 4'h0) ? 8'h00 : CUR[lv]);
	endtask
	// Counts pump rises over 100 cycles
	task automatic chk_pump(input logic [7:0] exp);
		logic prev;
		logic [7:0] rises;
		rises = 8'h00;
		prev = pump_clk;
		repeat (100) begin
			@(negedge clk);
			if (pump_clk === 1'b1 && prev === 1'b0) rises++;
			prev = pump_clk;
		end
		chk_val("pump rises", exp, rises);
	endtask
	task automatic scen_reset_state;
		chk_state(4'h0, 1'b1);
		chk_pump(8'h00);
	endtask
	// Bursts back to back with varied timing, count restarts each time
	task automatic scen_levels;
		for (int n = 1; n <= 15; n++) begin
			plc_host_model_i.send(n, 2 + n % 3, 3 + n % 4, L + 8);
			chk_state((n > 14) ? 4'hE : 4'(n), 1'b0);
		end
		chk_pump(8'h0A);
	endtask
	task automatic scen_shutdown;
		plc_host_model_i.idle(L + 8);
		chk_state(4'h0, 1'b1);
		chk_pump(8'h00);
		plc_host_model_i.send(1, 3, 3, L + 8);
		chk_state(4'h1, 1'b0);
		chk_pump(8'h0A);
	endtask
	// Slow burst near 15 kHz
	task automatic scen_slow;
		plc_host_model_i.send(3, 333, 334, L + 8);
		chk_state(4'h3, 1'b0);
	endtask
	// Reset in mid-run clears a latched level
	task automatic scen_reset_mid;
		plc_host_model_i.idle(2);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		chk_state(4'h0, 1'b1);
		chk_pump(8'h00);
		plc_host_model_i.send(2, 3, 4, L + 8);
		chk_state(4'h2, 1'b0);
	endtask
	task automatic stop_test;
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		errors++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		scen_reset_state();
		scen_levels();
		scen_slow();
		scen_shutdown();
		scen_reset_mid();
		stop_test();
	end
endmodule // pulse_count_led_level_ctrl_bench
